//--- pkg/adcs_consts.vh
// Notes on behaviour
// - Mode bit 1 means powered-down single-shot; also the power-up state.
// - Serial port and register access keep working while powered down.
// - Start bit write with mode bit 1 while idle powers up, clears bit, runs one conversion.
// - Single-shot returns to power-down once the result is available.
// - Start bit written during a conversion is ignored, never queued.
// - Mode bit 0 converts back to back, storing each result.
// - Continuous conversions keep starting whatever chip select does.
// - Continuous ends on mode bit write of 1 or on reset.
// - Chip select high resets serial state, ignores clock, releases pin.
// - Chip select low drives pin low if unread result, else high.
// - Result copied to shift register at transfer start, held until end.
// - Serial clock low for 30.8 ms resets the serial interface.
// - Data input sampled on serial clock falling edges, never driven.
// - Output shifts on rising edges, bit 15 first.
// - Pin falls on new result; in continuous mode rises 8 us before next ready unread.
// - Chip select high: weak pull-up unless pull-up enable bit is 0.
// - Results are 16-bit twos complement saturating at 7fff and 8000.
// - Last result stays buffered until a new conversion replaces it.
// - First 16 clocks carry config in and result out together.
// - Transfers are 32 bits with readback, or 16 bits with chip select.
// - Last two bytes of 32-bit transfer return config written first.
// - Config register is 16 bits, reset 058b.
// - Conversion register clears to 0000 at power-up.
`ifndef ADCS_CONSTS_VH
`define ADCS_CONSTS_VH
`define ADCS_CFG_RESET      16'h058b
`define ADCS_CONV_RESET     16'h0000
`define ADCS_BIT_START      15
`define ADCS_BIT_MODE       8
`define ADCS_BIT_PULLUP     3
`define ADCS_CLK_MHZ        200
`define ADCS_TIMEOUT_US     30800
`define ADCS_TIMEOUT_CYC    (`ADCS_TIMEOUT_US * `ADCS_CLK_MHZ)
`define ADCS_EARLY_US       8
`define ADCS_EARLY_CYC      (`ADCS_EARLY_US * `ADCS_CLK_MHZ)
`define ADCS_CONV_CYC       232000
`define ADCS_POS_FS         16'h7fff
`define ADCS_NEG_FS         16'h8000
`endif

//--- rtl/adcs_fifo.v
`timescale 1ns/100ps
`default_nettype none
module adcs_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	input  wire             mclk,
	input  wire             rst,
	input  wire             ce,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wp_r;
	reg [AW-1:0]    rp_r;
	reg [AW:0]      cnt_r;
	wire            push;
	wire            pop;
	wire [AW:0]     cnt_nxt;
	reg             room_r;
	// Registered room flag keeps the ready output straight from a flop
	assign in_ready  = room_r;
	assign out_valid = (cnt_r != 0);
	assign out_data  = mem[rp_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign cnt_nxt   = (push && !pop) ? cnt_r + 1'b1 :
	                   (pop && !push) ? cnt_r - 1'b1 : cnt_r;
	always @(posedge mclk)
	begin
		if (ce && push)
			mem[wp_r] <= in_data;
	end
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			wp_r  <= {AW{1'b0}};
			rp_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
			room_r <= 1'b1;
		end
		else if (ce)
		begin
			if (push)
				wp_r <= (wp_r == DEPTH-1) ? {AW{1'b0}} : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == DEPTH-1) ? {AW{1'b0}} : rp_r + 1'b1;
			cnt_r  <= cnt_nxt;
			room_r <= (cnt_nxt != DEPTH);
		end
	end
endmodule
`default_nettype wire

//--- rtl/adcs_top.v
`timescale 1ns/100ps
`default_nettype none
`include "adcs_consts.vh"
module adcs_top #(
	parameter TIMEOUT_CYC = `ADCS_TIMEOUT_CYC,
	parameter CONV_CYC    = `ADCS_CONV_CYC,
	parameter EARLY_CYC   = `ADCS_EARLY_CYC,
	parameter FIFO_DEPTH  = 8
) (
	input  wire        mclk,
	input  wire        rst,
	input  wire        ce,
	input  wire        cs_n,
	input  wire        sclk,
	input  wire        din,
	input  wire [15:0] sample_data,
	input  wire        sample_valid,
	output wire        sample_ready,
	output reg         data_out_ready_pin_o,
	output reg         data_out_ready_pin_oe,
	output reg         dout_pullup_enable,
	output reg         converting,
	output reg         powered_down,
	output reg  [15:0] config_value
);
	// ****************************************
	// Functions
	// ****************************************
	function [15:0] sat16;
		input [16:0] v;
		begin
			if (!v[16] && v[15])
				sat16 = `ADCS_POS_FS;
			else if (v[16] && !v[15])
				sat16 = `ADCS_NEG_FS;
			else
				sat16 = v[15:0];
		end
	endfunction

	// Last count of a conversion, shared by sequencer and buffer handshake
	function is_last;
		input [31:0] c;
		begin
			is_last = (c == CONV_CYC - 1);
		end
	endfunction

	// Stages two and three agree
	function settled;
		input [2:0] s;
		begin
			settled = (s[1] == s[2]);
		end
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Three stages; a change counts once stages two and three agree
	// Reset levels match the idle pins, so no false edge follows reset
	reg [2:0] cs_s_r;
	reg [2:0] sck_s_r;
	reg [2:0] din_s_r;
	reg       cs_q_r;
	reg       sck_q_r;
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cs_s_r  <= 3'h7;
			sck_s_r <= 3'h0;
			din_s_r <= 3'h0;
			cs_q_r  <= 1'b1;
			sck_q_r <= 1'b0;
		end
		else if (ce)
		begin
			cs_s_r  <= {cs_s_r[1:0], cs_n};
			sck_s_r <= {sck_s_r[1:0], sclk};
			din_s_r <= {din_s_r[1:0], din};
			if (cs_s_r[1] == cs_s_r[2])
				cs_q_r <= cs_s_r[2];
			if (sck_s_r[1] == sck_s_r[2])
				sck_q_r <= sck_s_r[2];
		end
	end
	wire sck_good = settled(sck_s_r);
	wire sck_rise = sck_good & sck_s_r[2] & ~sck_q_r;
	wire sck_fall = sck_good & ~sck_s_r[2] & sck_q_r;
	wire cs_good  = settled(cs_s_r);
	wire cs_fall  = cs_good & ~cs_s_r[2] & cs_q_r;
	wire din_now  = din_s_r[2];

	// ****************************************
	// Result buffer
	// ****************************************
	// Modulator output is queued so a stalled conversion loop backs up the source
	wire [15:0] fifo_data;
	wire        fifo_valid;
	reg         fifo_take;
	// AW must cover FIFO_DEPTH; both sized for eight words
	adcs_fifo #(
		.WIDTH    (16),
		.DEPTH    (FIFO_DEPTH),
		.AW       (3)
	) u_fifo (
		.mclk     (mclk),
		.rst      (rst),
		.ce       (ce),
		.in_data  (sample_data),
		.in_valid (sample_valid),
		.in_ready (sample_ready),
		.out_data (fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_take)
	);

	// ****************************************
	// Conversion sequencer
	// ****************************************
	localparam ST_DOWN = 2'h0;
	localparam ST_CONV = 2'h1;
	localparam ST_CONT = 2'h2;
	reg  [1:0]  state_r;
	reg  [31:0] ccnt_r;
	reg  [15:0] conv_r;
	reg         new_r;
	reg         early_r;
	reg         start_req_r;
	reg         cfg_upd_r;
	reg  [15:0] cfg_r;
	// A conversion waits at its last count until the buffer holds a sample
	wire        done = is_last(ccnt_r) & fifo_valid;
	wire        mode_single = cfg_r[`ADCS_BIT_MODE];
	reg         rd_clear_r;
	always @*
	begin
		fifo_take = 1'b0;
		if ((state_r == ST_CONV || state_r == ST_CONT) && is_last(ccnt_r))
			fifo_take = 1'b1;
	end
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= ST_DOWN;
			ccnt_r  <= 32'h0;
			conv_r  <= `ADCS_CONV_RESET;
			early_r <= 1'b0;
		end
		else if (ce)
		begin
			early_r <= 1'b0;
			case (state_r)
			ST_DOWN:
			begin
				ccnt_r <= 32'h0;
				if (start_req_r)
					state_r <= ST_CONV;
				else if (!mode_single)
					state_r <= ST_CONT;
			end
			ST_CONV:
			begin
				if (!is_last(ccnt_r))
					ccnt_r <= ccnt_r + 1'b1;
				else if (done)
				begin
					state_r <= mode_single ? ST_DOWN : ST_CONT;
					ccnt_r  <= 32'h0;
				end
			end
			ST_CONT:
			begin
				// early high before next ready
				// Two counts earlier: ready comes at count CONV_CYC - 1 and the early flag register adds one stage
				if (ccnt_r == CONV_CYC - 2 - EARLY_CYC && new_r)
					early_r <= 1'b1;
				if (!is_last(ccnt_r))
					ccnt_r <= ccnt_r + 1'b1;
				else if (done)
				begin
					ccnt_r <= 32'h0;
					if (mode_single)
						state_r <= ST_DOWN;
				end
			end
			default:
				state_r <= ST_DOWN;
			endcase
			// store result; held until replaced; saturation
			if (done)
				conv_r <= sat16({fifo_data[15], fifo_data});
		end
	end

	// ****************************************
	// Unread-result flag
	// ****************************************
	// Completion beats a same-cycle read so a fresh result is never lost
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
			new_r <= 1'b0;
		else if (ce)
		begin
			if (done)
				new_r <= 1'b1;
			else if (rd_clear_r || early_r)
				new_r <= 1'b0;
		end
	end

	// ****************************************
	// Serial engine
	// ****************************************
	reg  [5:0]  bitc_r;
	reg  [31:0] shout_r;
	reg  [15:0] shin_r;
	reg  [15:0] cfg_in_r;
	reg         active_r;
	reg  [31:0] tcnt_r;
	wire        sck_low_to = (tcnt_r == TIMEOUT_CYC - 1) & ~sck_q_r;
	// A rise that ends the time-out still opens the new frame
	wire        eng_clear  = cs_q_r | (sck_low_to & ~sck_rise);
	// frame of 16 or 32 clocks; chip select high ends either
	localparam [5:0] HALF_BITS = 6'h10;
	localparam [5:0] LAST_CFG  = 6'h0f;
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			bitc_r     <= 6'h0;
			shout_r    <= 32'h0;
			shin_r     <= 16'h0;
			cfg_in_r   <= 16'h0;
			active_r   <= 1'b0;
			rd_clear_r <= 1'b0;
			cfg_upd_r  <= 1'b0;
		end
		else if (ce)
		begin
			rd_clear_r <= 1'b0;
			cfg_upd_r  <= 1'b0;
			// deselect or time-out resets the engine
			if (eng_clear)
			begin
				bitc_r   <= 6'h0;
				active_r <= 1'b0;
			end
			else if (sck_rise)
			begin
				// lock result at transfer start; readback word staged
				if (!active_r)
				begin
					active_r   <= 1'b1;
					shout_r    <= {conv_r[14:0], cfg_r, 1'b0};
					rd_clear_r <= 1'b1;
				end
				else
					shout_r <= {shout_r[30:0], 1'b0};
			end
			else if (sck_fall && active_r)
			begin
				// sample on falling edge; config shares first 16 clocks
				bitc_r <= bitc_r + 1'b1;
				if (bitc_r < HALF_BITS)
					shin_r <= {shin_r[14:0], din_now};
				if (bitc_r == LAST_CFG)
				begin
					cfg_in_r  <= {shin_r[14:0], din_now};
					cfg_upd_r <= 1'b1;
					shout_r[31:16] <= {shin_r[14:0], din_now};
				end
			end
		end
	end

	// ****************************************
	// Serial clock time-out
	// ****************************************
	// serial clock low time-out
	// Counter parks at its end so the engine stays cleared until the next rise
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
			tcnt_r <= 32'h0;
		else if (ce)
		begin
			if (sck_q_r || cs_q_r)
				tcnt_r <= 32'h0;
			else if (!sck_low_to)
				tcnt_r <= tcnt_r + 1'b1;
		end
	end

	// ****************************************
	// Config register
	// ****************************************
	// config applied only through the mclk-synchronised strobe
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cfg_r       <= `ADCS_CFG_RESET;
			start_req_r <= 1'b0;
		end
		else if (ce)
		begin
			start_req_r <= 1'b0;
			if (cfg_upd_r)
			begin
				// Bit 15 never stored, so a start cannot replay on a later write
				cfg_r <= {1'b0, cfg_in_r[14:1], 1'b1};
				// start bit taken only while idle
				if (cfg_in_r[`ADCS_BIT_START] && state_r == ST_DOWN && cfg_in_r[`ADCS_BIT_MODE])
					start_req_r <= 1'b1;
			end
		end
	end

	// ****************************************
	// Output pin
	// ****************************************
	// Registered pin trails the detected clock edge by one cycle
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			data_out_ready_pin_o  <= 1'b1;
			data_out_ready_pin_oe <= 1'b0;
			dout_pullup_enable    <= 1'b1;
			converting            <= 1'b0;
			powered_down          <= 1'b1;
			config_value          <= `ADCS_CFG_RESET;
		end
		else if (ce)
		begin
			converting   <= (state_r != ST_DOWN);
			powered_down <= (state_r == ST_DOWN);
			config_value <= cfg_r;
			// pull-up only while deselected and enabled
			dout_pullup_enable <= cs_q_r & cfg_r[`ADCS_BIT_PULLUP];
			if (cs_q_r)
			begin
				data_out_ready_pin_oe <= 1'b0;
				data_out_ready_pin_o  <= 1'b1;
			end
			else if (active_r || (sck_rise && !cs_fall))
			begin
				data_out_ready_pin_oe <= 1'b1;
				if (sck_rise)
					data_out_ready_pin_o <= active_r ? shout_r[31] : conv_r[15];
			end
			else
			begin
				// ready level when selected and idle
				data_out_ready_pin_oe <= 1'b1;
				data_out_ready_pin_o  <= ~new_r;
			end
		end
	end
endmodule
`default_nettype wire

//--- tb/adcs_host.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// Host serial master
// ****************
module adcs_host (
	output var logic cs_n = 1'b1,
	output var logic sclk = 1'b0,
	output var logic din = 1'b0,
	input  wire logic pin
);
	task automatic xfer(input logic [31:0] tx, input int n, input bit hold,
		output logic [31:0] rx, output logic rdy);
		rx = 32'h0;
		cs_n = 1'b0;
		#100;
		rdy = pin;
		for (int i = n - 1; i >= 0; i--)
		begin
			sclk = 1'b1;
			din = tx[i];
			#24;
			sclk = 1'b0;
			// Sample late: the pin lags the clock by the sync stages
			#23;
			rx[i] = pin;
			#1;
		end
		#100;
		if (!hold)
			cs_n = 1'b1;
		#100;
	endtask
endmodule
`default_nettype wire

//--- tb/adcs_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// Control checker
// ****************
module adcs_monitor (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        cs_n,
	input wire logic        converting,
	input wire logic        powered_down,
	input wire logic        data_out_ready_pin_oe,
	input wire logic        dout_pullup_enable,
	input wire logic [15:0] config_value
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_idle; cs_n [*6]; endsequence
	sequence s_sel; !cs_n [*6]; endsequence
	a_pin_release: assert property (s_idle |-> !data_out_ready_pin_oe)
		else $error("pin driven while deselected");
	a_pin_drive: assert property (s_sel |-> data_out_ready_pin_oe)
		else $error("pin not driven while selected");
	a_pullup_idle: assert property (s_idle |-> dout_pullup_enable == config_value[3])
		else $error("pullup differs from config");
	a_pullup_sel: assert property (s_sel |-> !dout_pullup_enable)
		else $error("pullup on while selected");
	a_start_clear: assert property (!config_value[15])
		else $error("start bit kept");
	a_reset_cfg: assert property ($fell(rst) |-> config_value == 16'h058b && powered_down)
		else $error("bad reset state");
	a_pd_excl: assert property (!(powered_down && converting))
		else $error("converting while powered down");
	a_cont_keep: assert property (!config_value[8] && !$past(config_value[8]) |-> !$fell(converting))
		else $error("continuous conversion stopped");
	a_start_idle: assert property ($rose(converting) && config_value[8] |-> $past(powered_down, 2))
		else $error("start while busy");
	a_pd_leave: assert property (powered_down && !config_value[8] |-> ##[1:4] !powered_down)
		else $error("stayed down in continuous");
	a_oneshot_end: assert property ($fell(converting) && config_value[8] |-> ##[0:2] powered_down)
		else $error("no power down after result");
endmodule
bind adcs_top adcs_monitor u_mon (.mclk, .rst, .cs_n, .converting, .powered_down,
	.data_out_ready_pin_oe, .dout_pullup_enable, .config_value);
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// ****************
// Converter control bench
// ****************
module testbench;
	localparam int CONV = 400;
	localparam int EARLY = 8;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] sdata = 16'h0000;
	logic        svalid = 1'b0;
	logic        tog = 1'b0;
	wire logic   cs_n, sclk, din, sready, po, poe, pu, conv, pd;
	wire logic [15:0] cfg;
	// A released pin without pullup shows no stable level
	wire logic   pin = poe ? po : (pu ? 1'b1 : tog);
	int          failures = 0;
	int          cmp_count = 0;
	logic [31:0] rx;
	logic        rdy;
	always #2.5 mclk = ~mclk;
	always @(posedge mclk) tog <= ~tog;
	adcs_top #(.TIMEOUT_CYC(200), .CONV_CYC(CONV), .EARLY_CYC(EARLY)) u_dut (.mclk(mclk), .rst(rst),
		.ce(1'b1), .cs_n(cs_n), .sclk(sclk), .din(din), .sample_data(sdata), .sample_valid(svalid),
		.sample_ready(sready), .data_out_ready_pin_o(po), .data_out_ready_pin_oe(poe),
		.dout_pullup_enable(pu), .converting(conv), .powered_down(pd), .config_value(cfg));
	adcs_host u_host (.cs_n(cs_n), .sclk(sclk), .din(din), .pin(pin));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results;
		if (failures == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk);
		@(negedge mclk);
	endtask
	task automatic push(input logic [15:0] v);
		@(posedge mclk);
		sdata <= v;
		svalid <= 1'b1;
		@(posedge mclk);
		svalid <= 1'b0;
	endtask
	task automatic s_reset;
		chk(cfg, 16'h058b);
		chk({pd, conv, poe, pu}, 4'b1001);
	endtask
	task automatic s_readback;
		u_host.xfer({16'h0583, 16'h0583}, 32, 0, rx, rdy);
		chk(rdy, 1'b1);
		chk(rx[31:16], 16'h0000);
		chk(rx[15:0], 16'h0583);
		wt(10);
		chk(pu, 1'b0);
		u_host.xfer({16'h0000, 16'h058b}, 16, 0, rx, rdy);
		wt(10);
		chk(pu, 1'b1);
	endtask
	task automatic s_single;
		push(16'h1234);
		u_host.xfer({16'h0000, 16'h858b}, 16, 0, rx, rdy);
		wt(8);
		chk({conv, pd}, 2'b10);
		chk(cfg, 16'h058b);
		u_host.xfer({16'h0000, 16'h858b}, 16, 0, rx, rdy);
		wt(CONV);
		chk({conv, pd}, 2'b01);
		u_host.xfer({16'h0000, 16'h058b}, 16, 0, rx, rdy);
		chk(rdy, 1'b0);
		chk(rx[15:0], 16'h1234);
		u_host.xfer({16'h0000, 16'h058b}, 16, 0, rx, rdy);
		chk(rdy, 1'b1);
		chk(rx[15:0], 16'h1234);
	endtask
	task automatic s_early;
		int n;
		n = 0;
		// Chip select stays low so the pin shows the ready level throughout
		u_host.xfer(32'h0, 0, 1, rx, rdy);
		while (pin !== 1'b0 && n < 2000)
		begin
			@(posedge mclk);
			n++;
		end
		while (pin !== 1'b1 && n < 2000)
		begin
			@(posedge mclk);
			n++;
		end
		n = 0;
		// any readout would have to end before this fall
		while (pin !== 1'b0 && n < 2000)
		begin
			@(posedge mclk);
			n++;
		end
		chk(n, EARLY);
	endtask
	task automatic s_cont;
		for (int i = 0; i < 8; i++)
			push(i == 7 ? 16'h7fff : 16'(16'h0100 + i));
		wt(2);
		chk(sready, 1'b0);
		u_host.xfer({16'h0000, 16'h048b}, 16, 0, rx, rdy);
		s_early;
		wt(9 * CONV);
		chk({sready, conv}, 2'b11);
		u_host.xfer({16'h0000, 16'h048b}, 16, 0, rx, rdy);
		chk(rx[15:0], 16'h7fff);
		u_host.xfer({16'h0000, 16'h058b}, 16, 0, rx, rdy);
		push(16'h8000);
		wt(2 * CONV);
		chk({conv, pd}, 2'b01);
	endtask
	task automatic s_timeout;
		u_host.xfer({16'h0000, 16'h058b}, 5, 1, rx, rdy);
		wt(300);
		u_host.xfer({16'h058b, 16'h058b}, 32, 0, rx, rdy);
		chk(rx, {16'h8000, 16'h058b});
	endtask
	initial
	begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		wt(8);
		s_reset;
		s_readback;
		s_single;
		s_cont;
		s_timeout;
		results;
	end
	initial
	begin
		#100000;
		failures++;
		results;
	end
endmodule
`default_nettype wire
